// ### logic/asq_sequencer.v
// sample sequencers 2 and 3 with result fifos, fifo state and digital loopback
// assumes an AHB-Lite master on hclk and a converter core that answers each
// start pulse with one done pulse carrying a 10-bit result
//
// The AHB-Lite register port is this design's own decision.
`include "asq_map.vh"

// Behaviour
// - sequencer 2 control: four nibbles, upper zero
// - fifo reads return results in step order
// - full write or empty read sets fault flag
// - fifo state shows full, empty, head, tail
// - fifo state resets to empty, pointers zero
// - sequencer 3 single step, three-bit selector
// - sequencer 3 step always reads as last
// - loopback bit zero forces digital loopback mode
// - loopback fifo reads return loopback word
// - loopback word counter, flags, selector layout
// - loopback flags follow step last/balanced/temp config
module asq_sequencer (
  // clock and reset
  input wire hclk,
  input wire hresetn,
  // ahb-lite slave
  input wire hsel,
  input wire [31:0] haddr,
  input wire [1:0] htrans,
  input wire hwrite,
  input wire [2:0] hsize,
  input wire [31:0] hwdata,
  input wire hready,
  output reg [31:0] hrdata_ff,
  output reg hreadyout_ff,
  output reg hresp_ff,
  // sequence triggers
  input wire seq2_trigger,
  input wire seq3_trigger,
  // converter core
  output reg conv_start_ff,
  output reg [2:0] conv_input_selector_ff,
  output reg conv_balanced_ff,
  output reg conv_temp_ff,
  input wire conv_done,
  input wire [9:0] conv_result,
  // events and faults
  output reg [1:0] step_event_ff,
  output reg [1:0] overflow_status_ff,
  output reg [1:0] underflow_status_ff
);

  // sequencer states
  localparam ST_IDLE = 2'b01;
  localparam ST_WAIT = 2'b10;

  // pick one 4-bit step field out of a 16-bit register
  function [3:0] nibble;
    input [15:0] word;
    input [1:0] step;
    reg [15:0] shifted;
    begin
      shifted = word >> {step, 2'b00};
      nibble = shifted[3:0];
    end
  endfunction

  // build a fifo state word
  function [31:0] fstat;
    input full;
    input empty;
    input [1:0] head;
    input [1:0] tail;
    begin
      fstat = ({31'h0, full} << `ASQ_FSTAT_FULL_BIT) |
              ({31'h0, empty} << `ASQ_FSTAT_EMPTY_BIT) |
              ({30'h0, head} << `ASQ_FSTAT_HEAD_LSB) |
              ({30'h0, tail} << `ASQ_FSTAT_TAIL_LSB);
    end
  endfunction

  // configuration registers
  reg [15:0] ctl2_ff; // sequencer 2 step nibbles
  reg [15:0] mux2_ff; // sequencer 2 selectors
  reg [3:0] ctl3_ff; // sequencer 3 step nibble, last bit fixed
  reg [2:0] mux3_ff; // sequencer 3 selector
  reg lb_ff; // loopback mode
  reg [9:0] lb_word_ff; // last loopback word
  reg [3:0] lb_cnt_ff; // loopback sample numbering
  // bus data phase
  reg dph_ff;
  reg dph_write_ff;
  reg [11:0] dph_addr_ff;
  // sequencer control
  reg [1:0] state_ff;
  reg pend2_ff;
  reg pend3_ff;
  reg cur3_ff; // step in flight belongs to sequencer 3
  reg [1:0] step2_ff; // next step of sequencer 2
  reg [3:0] cfg_ff; // nibble of the step in flight
  // fifos: 3-bit pointers for 4 entries, 1-bit for 1 entry
  reg [9:0] fifo2_ff [0:3];
  reg [2:0] wr2_ff;
  reg [2:0] rd2_ff;
  reg [9:0] fifo3_ff;
  reg wr3_ff;
  reg rd3_ff;

  // fifo flags, the wrap bit tells full from empty
  wire empty2 = (wr2_ff == rd2_ff);
  wire full2 = (wr2_ff[2] != rd2_ff[2]) && (wr2_ff[1:0] == rd2_ff[1:0]);
  wire empty3 = (wr3_ff == rd3_ff);
  wire full3 = (wr3_ff != rd3_ff);

  // address phase accept and data phase strobes
  wire accept = hsel && htrans[1] && hready;
  wire rd_strobe = dph_ff && !dph_write_ff;
  wire wr_strobe = dph_ff && dph_write_ff;
  wire pop2 = rd_strobe && (dph_addr_ff == `ASQ_SEQ2_RESULT_FIFO);
  wire pop3 = rd_strobe && (dph_addr_ff == `ASQ_SEQ3_RESULT_FIFO);

  // completion of the step in flight; loopback needs no converter answer
  wire step_done = (state_ff == ST_WAIT) && (lb_ff || conv_done);
  wire is_last = cur3_ff || cfg_ff[`ASQ_NIB_LAST] ||
                 (step2_ff == `ASQ_SEQ2_LAST_STEP);
  wire push2 = step_done && !cur3_ff;
  wire push3 = step_done && cur3_ff;

  // loopback word of the step in flight
  wire [9:0] lb_word = {lb_cnt_ff, !is_last, cfg_ff[`ASQ_NIB_BALANCED],
                        cfg_ff[`ASQ_NIB_TEMP], conv_input_selector_ff};
  wire [9:0] sample = lb_ff ? lb_word : conv_result;

  // read mux
  reg [31:0] rd_val;
  always @* begin
    rd_val = 32'h00000000;
    case (dph_addr_ff)
      `ASQ_SEQ2_INPUT_SELECT: rd_val = {16'h0000, mux2_ff};
      `ASQ_SEQ2_STEP_CONTROL: rd_val = {16'h0000, ctl2_ff};
      `ASQ_SEQ2_RESULT_FIFO: rd_val = {22'h000000, fifo2_ff[rd2_ff[1:0]]};
      `ASQ_SEQ2_FIFO_STATE: rd_val = fstat(full2, empty2, rd2_ff[1:0], wr2_ff[1:0]);
      `ASQ_SEQ3_INPUT_SELECT: rd_val = {29'h00000000, mux3_ff};
      `ASQ_SEQ3_STEP_CONTROL: rd_val = {28'h0000000, ctl3_ff};
      `ASQ_SEQ3_RESULT_FIFO: rd_val = {22'h000000, fifo3_ff};
      `ASQ_SEQ3_FIFO_STATE: rd_val = fstat(full3, empty3, {1'b0, rd3_ff}, {1'b0, wr3_ff});
      `ASQ_FAULT_STATUS: rd_val = {24'h000000, 2'h0, underflow_status_ff,
                                   2'h0, overflow_status_ff};
      `ASQ_DIGITAL_LOOP_TEST: rd_val = {22'h000000, lb_word_ff};
      default: rd_val = 32'h00000000;
    endcase
  end

  // ahb-lite slave: one wait state so read data leaves a flip-flop
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      dph_ff <= 1'b0;
      dph_write_ff <= 1'b0;
      dph_addr_ff <= 12'h000;
      hrdata_ff <= 32'h00000000;
      hreadyout_ff <= 1'b1;
      hresp_ff <= 1'b0;
    end else begin
      hresp_ff <= 1'b0; // always okay, unmapped reads give zero
      if (dph_ff) begin
        dph_ff <= 1'b0;
        hreadyout_ff <= 1'b1;
        hrdata_ff <= dph_write_ff ? 32'h00000000 : rd_val;
      end else if (accept) begin
        dph_ff <= 1'b1;
        dph_write_ff <= hwrite;
        dph_addr_ff <= haddr[11:0];
        hreadyout_ff <= 1'b0;
      end
    end
  end

  // software-written configuration
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ctl2_ff <= `ASQ_CTL2_RESET;
      mux2_ff <= `ASQ_MUX_RESET;
      ctl3_ff <= `ASQ_CTL3_RESET;
      mux3_ff <= 3'h0;
      lb_ff <= 1'b0;
    end else if (wr_strobe) begin
      case (dph_addr_ff)
        `ASQ_SEQ2_STEP_CONTROL: ctl2_ff <= hwdata[15:0];
        // reserved bit of each selector field stays zero
        `ASQ_SEQ2_INPUT_SELECT: mux2_ff <= hwdata[15:0] & 16'h7777;
        // last-step bit is not writable and stays set
        `ASQ_SEQ3_STEP_CONTROL: ctl3_ff <= (hwdata[3:0] & `ASQ_CTL3_WMASK) |
                                           `ASQ_CTL3_RESET;
        `ASQ_SEQ3_INPUT_SELECT: mux3_ff <= hwdata[2:0];
        `ASQ_DIGITAL_LOOP_TEST: lb_ff <= hwdata[`ASQ_LB_FORCE_BIT];
        default: lb_ff <= lb_ff;
      endcase
    end
  end

  // fault flags: write one to clear, a new event beats the clear
  wire clr_fault = wr_strobe && (dph_addr_ff == `ASQ_FAULT_STATUS);
  wire [1:0] ovf_set = {push3 && full3, push2 && full2};
  wire [1:0] unf_set = {pop3 && empty3, pop2 && empty2};
  wire [1:0] ovf_clr = clr_fault ? hwdata[1:0] : 2'h0;
  wire [1:0] unf_clr = clr_fault ? hwdata[5:4] : 2'h0;
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      overflow_status_ff <= 2'h0;
      underflow_status_ff <= 2'h0;
    end else begin
      overflow_status_ff <= (overflow_status_ff & ~ovf_clr) | ovf_set;
      underflow_status_ff <= (underflow_status_ff & ~unf_clr) | unf_set;
    end
  end

  // result fifos; a write to a full fifo is dropped, a read of an empty one
  // leaves the pointers alone
  integer i;
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      for (i = 0; i < `ASQ_SEQ2_STEPS; i = i + 1) begin
        fifo2_ff[i] <= 10'h000;
      end
      fifo3_ff <= 10'h000;
      wr2_ff <= 3'h0;
      rd2_ff <= 3'h0;
      wr3_ff <= 1'b0;
      rd3_ff <= 1'b0;
    end else begin
      if (push2 && !full2) begin
        fifo2_ff[wr2_ff[1:0]] <= sample;
        wr2_ff <= wr2_ff + 3'h1;
      end
      if (pop2 && !empty2) begin
        rd2_ff <= rd2_ff + 3'h1;
      end
      if (push3 && !full3) begin
        fifo3_ff <= sample;
        wr3_ff <= !wr3_ff;
      end
      if (pop3 && !empty3) begin
        rd3_ff <= !rd3_ff;
      end
    end
  end

  // configuration of the step about to start
  wire pick3 = pend3_ff;
  wire [3:0] nxt_cfg = pick3 ? ctl3_ff : nibble(ctl2_ff, step2_ff);
  wire [3:0] sel_nib = nibble(mux2_ff, step2_ff);
  wire [2:0] nxt_sel = pick3 ? mux3_ff : sel_nib[2:0];

  // sequencer: sequencer 3 wins over sequencer 2 between steps, so a long
  // sequence 2 run cannot starve the single-step sequencer
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      state_ff <= ST_IDLE;
      pend2_ff <= 1'b0;
      pend3_ff <= 1'b0;
      cur3_ff <= 1'b0;
      step2_ff <= 2'h0;
      cfg_ff <= 4'h0;
      conv_start_ff <= 1'b0;
      conv_input_selector_ff <= 3'h0;
      conv_balanced_ff <= 1'b0;
      conv_temp_ff <= 1'b0;
      step_event_ff <= 2'h0;
      lb_cnt_ff <= 4'h0;
      lb_word_ff <= 10'h000;
    end else begin
      conv_start_ff <= 1'b0;
      step_event_ff <= 2'h0;
      case (state_ff)
        ST_IDLE: begin
          pend2_ff <= pend2_ff | seq2_trigger;
          pend3_ff <= pend3_ff | seq3_trigger;
          if (pend2_ff || pend3_ff) begin
            cur3_ff <= pick3;
            cfg_ff <= nxt_cfg;
            conv_input_selector_ff <= nxt_sel;
            conv_balanced_ff <= nxt_cfg[`ASQ_NIB_BALANCED];
            conv_temp_ff <= nxt_cfg[`ASQ_NIB_TEMP];
            conv_start_ff <= !lb_ff; // loopback keeps the core quiet
            state_ff <= ST_WAIT;
          end
        end
        ST_WAIT: begin
          // a trigger for the other sequencer is kept; a repeat trigger is dropped unless it arrives as the last step completes
          pend2_ff <= pend2_ff | seq2_trigger;
          pend3_ff <= pend3_ff | seq3_trigger;
          if (step_done) begin
            state_ff <= ST_IDLE;
            step_event_ff <= {cur3_ff, !cur3_ff} &
                             {2{cfg_ff[`ASQ_NIB_IRQ]}};
            if (lb_ff) begin
              lb_word_ff <= lb_word;
              lb_cnt_ff <= lb_cnt_ff + 4'h1;
            end
            if (cur3_ff) begin
              pend3_ff <= seq3_trigger;
            end else if (is_last) begin
              // a sequence without a marked last step stops after step 3
              pend2_ff <= seq2_trigger;
              step2_ff <= 2'h0;
            end else begin
              step2_ff <= step2_ff + 2'h1;
            end
          end
        end
        default: state_ff <= ST_IDLE;
      endcase
    end
  end

endmodule

// ### common/asq_map.vh
// register map, field positions and reset values of the sequencer 2/3 block
// assumes a 32-bit AHB-Lite register window, word aligned, one clock domain
`ifndef ASQ_MAP_VH
`define ASQ_MAP_VH

// register byte offsets
`define ASQ_SEQ2_INPUT_SELECT 12'h080
`define ASQ_SEQ2_STEP_CONTROL 12'h084
`define ASQ_SEQ2_RESULT_FIFO 12'h088
`define ASQ_SEQ2_FIFO_STATE 12'h08C
`define ASQ_SEQ3_INPUT_SELECT 12'h0A0
`define ASQ_SEQ3_STEP_CONTROL 12'h0A4
`define ASQ_SEQ3_RESULT_FIFO 12'h0A8
`define ASQ_SEQ3_FIFO_STATE 12'h0AC
`define ASQ_FAULT_STATUS 12'h0F0
`define ASQ_DIGITAL_LOOP_TEST 12'h100

// step control nibble layout
`define ASQ_NIB_BALANCED 0
`define ASQ_NIB_LAST 1
`define ASQ_NIB_IRQ 2
`define ASQ_NIB_TEMP 3

// fifo state word layout
`define ASQ_FSTAT_TAIL_LSB 0
`define ASQ_FSTAT_HEAD_LSB 4
`define ASQ_FSTAT_EMPTY_BIT 8
`define ASQ_FSTAT_FULL_BIT 12

// reset values and write masks
`define ASQ_CTL2_RESET 16'h0000
`define ASQ_MUX_RESET 16'h0000
`define ASQ_CTL3_RESET 4'h2
`define ASQ_CTL3_WMASK 4'hD
`define ASQ_MUX3_WMASK 16'h0007

// loopback force bit and loopback word layout
`define ASQ_LB_FORCE_BIT 0
`define ASQ_LB_CONTINUOUS_FLAG_BIT 5
`define ASQ_LB_CNT_LSB 6

// sequencer 2 fifo depth in entries and last step index
`define ASQ_SEQ2_STEPS 4
`define ASQ_SEQ2_LAST_STEP 2'h3

`endif

// ### verification/asq_sva.sv
// concurrent checks on the ports of the sequencer block
// assumes the single hclk domain with hresetn as asynchronous active-low reset
module asq_sva (
  // clock and reset
  input wire hclk,
  input wire hresetn,
  // register bus
  input wire hsel,
  input wire [1:0] htrans,
  input wire hready,
  input wire hreadyout_ff,
  input wire hresp_ff,
  input wire [31:0] hrdata_ff,
  // converter side and status
  input wire conv_start_ff,
  input wire [2:0] conv_input_selector_ff,
  input wire conv_balanced_ff,
  input wire conv_temp_ff,
  input wire [1:0] step_event_ff,
  input wire [1:0] underflow_status_ff
);
  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);
  // every accepted transfer costs exactly one wait state
  a_ready_one_wait: assert property (hsel && htrans[1] && hready |=> !hreadyout_ff ##1 hreadyout_ff)
    else $error("wait state not exactly one cycle");
  a_ready_low_once: assert property (!hreadyout_ff |=> hreadyout_ff)
    else $error("ready held low too long");
  a_okay_resp: assert property (hresp_ff == 1'b0)
    else $error("response not okay");
  // read data must not drift outside a data phase
  a_rdata_hold: assert property ($past(hreadyout_ff) |-> $stable(hrdata_ff))
    else $error("read data changed outside data phase");
  a_start_pulse: assert property (conv_start_ff |=> !conv_start_ff)
    else $error("start longer than one cycle");
  // step setup stays put for two cycles after each start pulse
  a_step_setup_hold: assert property (conv_start_ff |=>
    $stable({conv_input_selector_ff, conv_balanced_ff, conv_temp_ff}) [*2])
    else $error("step setup moved during conversion");
  a_event_pulse: assert property (step_event_ff != 2'b00 |=> step_event_ff == 2'b00)
    else $error("step event longer than one cycle");
  // sequencer 2 underflow only appears as a read data phase completes
  a_under_cause: assert property ($rose(underflow_status_ff[0]) |-> !$past(hreadyout_ff))
    else $error("underflow without a read");
endmodule

bind asq_sequencer asq_sva u_sva (.hclk, .hresetn, .hsel, .htrans, .hready, .hreadyout_ff,
  .hresp_ff, .hrdata_ff, .conv_start_ff, .conv_input_selector_ff, .conv_balanced_ff,
  .conv_temp_ff, .step_event_ff, .underflow_status_ff);

// ### verification/asq_core_model.sv
// behavioural converter core: one done pulse per start, prompt or slow
// assumes start is a one-cycle pulse with the selector held until done
module asq_core_model (
  // clock and reset
  input wire hclk,
  input wire hresetn,
  // control from bench
  input wire slow,
  // converter handshake
  input wire conv_start_ff,
  input wire [2:0] conv_input_selector_ff,
  output logic conv_done,
  output logic [9:0] conv_result
);
  int cnt; // conversions finished, coded into the result
  int dly; // cycles left before done, -1 when idle
  // result bus toggles when not valid so a stale sample never looks right
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      conv_done <= 1'b0;
      conv_result <= 10'h155;
      cnt <= 0;
      dly <= -1;
    end else begin
      conv_done <= 1'b0;
      conv_result <= ~conv_result;
      if (conv_start_ff) begin
        dly <= slow ? 3 : 0;
      end else if (dly > 0) begin
        dly <= dly - 1;
      end else if (dly == 0) begin
        conv_done <= 1'b1;
        conv_result <= {7'(cnt), conv_input_selector_ff};
        cnt <= cnt + 1;
        dly <= -1;
      end
    end
  end
endmodule

// ### verification/testbench.sv
// self-checking bench for the sequencer block over AHB-Lite
// assumes one wait state per transfer and the core model on the converter side
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  logic hclk = 1'b0, hresetn = 1'b0, hsel = 1'b0, hwrite = 1'b0, slow = 1'b0;
  logic seq2_trigger = 1'b0, seq3_trigger = 1'b0;
  logic [1:0] htrans = 2'b00;
  logic [31:0] haddr = 32'h0, hwdata = 32'h0, r, mux2, mux3, e3;
  wire [31:0] hrdata_ff;
  wire hreadyout_ff, hresp_ff, conv_start_ff, conv_balanced_ff, conv_temp_ff, conv_done;
  wire [2:0] conv_input_selector_ff;
  wire [9:0] conv_result;
  wire [1:0] step_event_ff, overflow_status_ff, underflow_status_ff;
  integer err_total = 0, n_tests = 0, seed = 47487, conv_n = 0;
  logic [31:0] exp_q[$]; // expected fifo words in step order
  logic [3:0] c;
  integer ev2 = 0, ev3 = 0; // step event pulses seen per sequencer
  always #2.5 hclk = ~hclk;
  // count step event pulses so the irq-enable nibble bit is checked at the port
  always @(posedge hclk) begin
    if (step_event_ff[0]) ev2 <= ev2 + 1;
    if (step_event_ff[1]) ev3 <= ev3 + 1;
  end
  asq_sequencer uut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(3'b010), .hwdata(hwdata), .hready(hreadyout_ff),
    .hrdata_ff(hrdata_ff), .hreadyout_ff(hreadyout_ff), .hresp_ff(hresp_ff),
    .seq2_trigger(seq2_trigger), .seq3_trigger(seq3_trigger), .conv_start_ff(conv_start_ff),
    .conv_input_selector_ff(conv_input_selector_ff), .conv_balanced_ff(conv_balanced_ff),
    .conv_temp_ff(conv_temp_ff), .conv_done(conv_done), .conv_result(conv_result),
    .step_event_ff(step_event_ff), .overflow_status_ff(overflow_status_ff),
    .underflow_status_ff(underflow_status_ff));
  asq_core_model u_core (.hclk(hclk), .hresetn(hresetn), .slow(slow),
    .conv_start_ff(conv_start_ff), .conv_input_selector_ff(conv_input_selector_ff),
    .conv_done(conv_done), .conv_result(conv_result));
  // one single word transfer; address held until ready, then data phase
  task automatic bus(input logic wr, input logic [11:0] a, input logic [31:0] wd,
                     output logic [31:0] rd);
    @(posedge hclk);
    hsel <= 1'b1; htrans <= 2'b10; hwrite <= wr; haddr <= {20'h0, a};
    do @(posedge hclk); while (hreadyout_ff !== 1'b1);
    hsel <= 1'b0; htrans <= 2'b00; hwdata <= wd;
    do @(posedge hclk); while (hreadyout_ff !== 1'b1);
    rd = hrdata_ff;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      err_total++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic rchk(input logic [11:0] a, input logic [31:0] exp);
    bus(1'b0, a, 32'h0, r);
    chk(r, exp);
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    bus(1'b1, a, d, r);
  endtask
  // polling bounded only by the watchdog: the core may be slow
  task automatic poll(input logic [11:0] a, input logic [31:0] m, input logic [31:0] v);
    do bus(1'b0, a, 32'h0, r); while ((r & m) !== v);
  endtask
  task automatic trig(input int s);
    @(posedge hclk);
    seq2_trigger <= (s == 2);
    seq3_trigger <= (s == 3);
    @(posedge hclk);
    seq2_trigger <= 1'b0;
    seq3_trigger <= 1'b0;
  endtask
  task automatic test_done;
    $display("comparisons %0d mismatches %0d", n_tests, err_total);
    if (err_total == 0 && n_tests > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  initial begin
    #100000;
    err_total++;
    test_done;
  end
  initial begin
    repeat (4) @(posedge hclk);
    hresetn <= 1'b1;
    rchk(12'h08C, 32'h100);
    rchk(12'h0AC, 32'h100);
    rchk(12'h0A4, 32'h2);
    rchk(12'h040, 32'h0);
    wr(12'h084, 32'hFFFFFFFF);
    rchk(12'h084, 32'h0000FFFF);
    wr(12'h0A0, 32'hFFFFFFFF);
    rchk(12'h0A0, 32'h7);
    wr(12'h0A4, 32'h0);
    rchk(12'h0A4, 32'h2);
    $display("test registers finished");
    // three steps, last mark on step two, irq on step zero
    mux2 = $random(seed) & 32'h7777;
    wr(12'h080, mux2);
    wr(12'h084, 32'h0204);
    for (int k = 0; k < 3; k++) begin
      exp_q.push_back({22'h0, 7'(conv_n), 3'(mux2 >> (4 * k))});
      conv_n++;
    end
    trig(2);
    poll(12'h08C, 32'h3, 32'h3);
    repeat (3) rchk(12'h088, exp_q.pop_front());
    rchk(12'h08C, 32'h133);
    bus(1'b0, 12'h088, 32'h0, r);
    rchk(12'h0F0, 32'h10);
    chk({30'h0, underflow_status_ff}, 32'h1);
    wr(12'h0F0, 32'h10);
    $display("test sequencer two finished");
    // slow core, second run into a full fifo
    slow <= 1'b1;
    mux3 = $random(seed) & 32'h7;
    wr(12'h0A0, mux3);
    wr(12'h0A4, 32'h4);
    e3 = {22'h0, 7'(conv_n), mux3[2:0]};
    conv_n += 2;
    trig(3);
    poll(12'h0AC, 32'h1000, 32'h1000);
    rchk(12'h0AC, 32'h1001);
    trig(3);
    poll(12'h0F0, 32'h2, 32'h2);
    rchk(12'h0F0, 32'h2);
    chk({30'h0, overflow_status_ff}, 32'h2);
    rchk(12'h0A8, e3);
    rchk(12'h0AC, 32'h111);
    $display("test sequencer three finished");
    // loopback: step zero differential, step one temp sensor and last
    wr(12'h100, 32'h1);
    wr(12'h084, 32'h00A1);
    trig(2);
    poll(12'h08C, 32'h3, 32'h1);
    bus(1'b0, 12'h088, 32'h0, r);
    c = r[9:6];
    chk(r & 32'hFFFFFC3F, {26'h0, 3'b110, mux2[2:0]});
    bus(1'b0, 12'h088, 32'h0, r);
    chk(r, {22'h0, c + 4'h1, 3'b001, mux2[6:4]});
    rchk(12'h100, {22'h0, c + 4'h1, 3'b001, mux2[6:4]});
    wr(12'h100, 32'h0);
    $display("test loopback finished");
    chk(ev2, 1);
    chk(ev3, 2);
    test_done;
  end
endmodule
